//--- include/som_cfg.svh
// Register map, codes and timing constants of the status output mapper
`ifndef SOM_CFG_SVH
`define SOM_CFG_SVH
`define SOM_AW         6
`define SOM_OC_FUNC    6'h00
`define SOM_RY_FUNC    6'h04
`define SOM_POLARITY   6'h08
`define SOM_OC_ON      6'h0C
`define SOM_OC_OFF     6'h10
`define SOM_RY_ON      6'h14
`define SOM_RY_OFF     6'h18
`define SOM_STATUS     6'h1C
`define SOM_IRQ_STAT   6'h20
`define SOM_IRQ_MASK   6'h24
`define SOM_NOASSIGN   7'h7F
`define SOM_OC_FN_RST  7'h7F
`define SOM_RY_FN_RST  7'h05
`define SOM_POL_RST    2'h2
`define SOM_DLY_MAX    10'h3E8
`define SOM_STEP_NS    100000000
`define SOM_CLK_NS     20
`define SOM_PRE_W      23
`define SOM_RESP_OK    2'h0
`define SOM_RESP_ERR   2'h2
`define SOM_C_RUN      6'h00
`define SOM_C_FA1      6'h01
`define SOM_C_FA2      6'h02
`define SOM_C_OL       6'h03
`define SOM_C_OD       6'h04
`define SOM_C_AL       6'h05
`define SOM_C_FA3      6'h06
`define SOM_C_UV       6'h09
`define SOM_C_RNT      6'h0B
`define SOM_C_ONT      6'h0C
`define SOM_C_THM      6'h0D
`define SOM_C_ZS       6'h15
`define SOM_C_DISC     6'h1B
`define SOM_C_FBV      6'h1F
`define SOM_C_COMM     6'h20
`define SOM_C_LOGIC_RESULT_ONE     6'h21
`define SOM_C_START    6'h29
`define SOM_C_OHF      6'h2A
`define SOM_C_LOC      6'h2B
`define SOM_C_RDY      6'h32
`define SOM_C_FWD      6'h33
`define SOM_C_REV      6'h34
`define SOM_C_MJA      6'h35
`define SOM_C_WC       6'h36
`define SOM_C_FSRC     6'h3A
`define SOM_C_RSRC     6'h3B
`define SOM_C_M2       6'h3C
`endif

//--- include/som_pkg.sv
// Types of the status output mapper
package som_pkg;
  typedef struct packed {
    logic [1:0][6:0] func;
    logic [1:0]      pol;
    logic [1:0][9:0] on_dly;
    logic [1:0][9:0] off_dly;
    logic [1:0][9:0] cnt;
    logic [1:0]      act;
    logic [22:0]     pre;
    logic            tick;
    logic [1:0]      ist;
    logic [1:0]      imask;
    logic            irq;
    logic            oc;
    logic            mk;
    logic            brk;
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
    logic            aw_got;
    logic            w_got;
    logic [5:0]      awaddr;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
  } som_state_t;
endpackage : som_pkg

//--- src/som_mapper.sv
// Status output mapper: open-collector and relay terminals with AXI4-Lite registers
// Operation
// [R1] Two assignable outputs, open-collector and relay, each with own function selector.
// [R2] Codes 00,01,02,06: running, constant speed, overreached, set frequency reached.
// [R3] Codes 03,05,09,13,42,43,53: overload, trip, undervoltage, thermal, heatsink, low current, major.
// [R4] Codes 11,12,21: run time over, powered time over, zero frequency.
// [R5] Codes 04,31: process deviation and feedback comparison.
// [R6] Codes 27,54: analog input loss and window comparator.
// [R7] Codes 32,33: communication loss and logic result one.
// [R8] Codes 41,50,51,52: start contact, ready, forward, reverse.
// [R9] Codes 58,59,60: frequency source, run source, second motor.
// [R10] No-assignment or unsupported code keeps the output inactive.
// [R11] Per-output polarity: 00 normally open, 01 normally closed.
// [R12] Normally open: closed while condition active, open otherwise.
// [R13] Normally closed: open while condition active, closed otherwise.
// [R14] Relay polarity resets to 01; unpowered make open, break closed.
// [R15] Zero delay: output follows condition at once.
// [R16] Independent on-delay and off-delay per output.
// [R17] Delays span 0.0 to 100.0 seconds.
// [R18] Condition shorter than the delay does not change the output.
// [R19] Delays count 0.1 s steps from divided clock; polarity after delay.
`timescale 1ns/1ps
`include "som_cfg.svh"
`default_nettype none
module som_mapper #(
  parameter int TICK_CYCLES = `SOM_STEP_NS / `SOM_CLK_NS
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic [`SOM_AW-1:0]  s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [`SOM_AW-1:0]  s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                run_state,
  input  wire logic                constant_speed_reached,
  input  wire logic                frequency_overreached,
  input  wire logic                set_frequency_reached,
  input  wire logic                overload_notice,
  input  wire logic                process_deviation,
  input  wire logic                fault_trip_flag,
  input  wire logic                undervoltage_flag,
  input  wire logic                run_time_over,
  input  wire logic                powered_time_over,
  input  wire logic                thermal_warning,
  input  wire logic                zero_frequency_detect,
  input  wire logic                analog_input_loss,
  input  wire logic                feedback_compare,
  input  wire logic                comm_link_loss,
  input  wire logic                logic_result_one,
  input  wire logic                start_contact,
  input  wire logic                heatsink_warning,
  input  wire logic                low_current_flag,
  input  wire logic                drive_ready,
  input  wire logic                forward_rotation,
  input  wire logic                reverse_rotation,
  input  wire logic                major_fault,
  input  wire logic                window_comparator_flag,
  input  wire logic                freq_cmd_source_flag,
  input  wire logic                run_cmd_source_flag,
  input  wire logic                second_motor_active,
  output logic                     oc_output_on,
  output logic                     relay_make_closed,
  output logic                     relay_break_closed,
  output logic                     irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_ok(input logic [`SOM_AW-1:0] a);
    case (a)
      `SOM_OC_FUNC, `SOM_RY_FUNC, `SOM_POLARITY, `SOM_OC_ON, `SOM_OC_OFF,
      `SOM_RY_ON, `SOM_RY_OFF, `SOM_STATUS, `SOM_IRQ_STAT,
      `SOM_IRQ_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction : addr_ok

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction : merge

  function automatic logic [9:0] clamp(input logic [31:0] v);
    clamp = (v > {22'h0, `SOM_DLY_MAX}) ? `SOM_DLY_MAX : v[9:0]; // [R17]
  endfunction : clamp

  function automatic logic sel_cond(input logic [6:0]  code,
                                    input logic [63:0] cv);
    sel_cond = code[6] ? 1'b0 : cv[code[5:0]]; // [R1] [R10]
  endfunction : sel_cond

  ////////////////////////////////////////////////////////////////////////////
  // Condition vector indexed by function code

  logic [63:0] cv;
  logic [1:0]  cond;

  always_comb begin
    cv = 64'h0;
    cv[`SOM_C_RUN]   = run_state;               // [R2]
    cv[`SOM_C_FA1]   = constant_speed_reached;  // [R2]
    cv[`SOM_C_FA2]   = frequency_overreached;   // [R2]
    cv[`SOM_C_FA3]   = set_frequency_reached;   // [R2]
    cv[`SOM_C_OL]    = overload_notice;         // [R3]
    cv[`SOM_C_AL]    = fault_trip_flag;         // [R3]
    cv[`SOM_C_UV]    = undervoltage_flag;       // [R3]
    cv[`SOM_C_THM]   = thermal_warning;         // [R3]
    cv[`SOM_C_OHF]   = heatsink_warning;        // [R3]
    cv[`SOM_C_LOC]   = low_current_flag;        // [R3]
    cv[`SOM_C_MJA]   = major_fault;             // [R3]
    cv[`SOM_C_RNT]   = run_time_over;           // [R4]
    cv[`SOM_C_ONT]   = powered_time_over;       // [R4]
    cv[`SOM_C_ZS]    = zero_frequency_detect;   // [R4]
    cv[`SOM_C_OD]    = process_deviation;       // [R5]
    cv[`SOM_C_FBV]   = feedback_compare;        // [R5]
    cv[`SOM_C_DISC]  = analog_input_loss;       // [R6]
    cv[`SOM_C_WC]    = window_comparator_flag;  // [R6]
    cv[`SOM_C_COMM]  = comm_link_loss;          // [R7]
    cv[`SOM_C_LOGIC_RESULT_ONE]  = logic_result_one;        // [R7]
    cv[`SOM_C_START] = start_contact;           // [R8]
    cv[`SOM_C_RDY]   = drive_ready;             // [R8]
    cv[`SOM_C_FWD]   = forward_rotation;        // [R8]
    cv[`SOM_C_REV]   = reverse_rotation;        // [R8]
    cv[`SOM_C_FSRC]  = freq_cmd_source_flag;    // [R9]
    cv[`SOM_C_RSRC]  = run_cmd_source_flag;     // [R9]
    cv[`SOM_C_M2]    = second_motor_active;     // [R9]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  som_pkg::som_state_t q;
  som_pkg::som_state_t n;
  logic [31:0]         wm;
  logic [9:0]          dly;

  always_comb begin
    n = q;
    wm = 32'h0;
    dly = 10'h0;
    cond[0] = sel_cond(q.func[0], cv);
    cond[1] = sel_cond(q.func[1], cv);
    // Step divider
    n.tick = 1'b0;
    if (q.pre == `SOM_PRE_W'(TICK_CYCLES - 1)) begin
      n.pre = '0;
      n.tick = 1'b1; // [R19]
    end else begin
      n.pre = q.pre + `SOM_PRE_W'(1);
    end
    // Write channel
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (n.aw_got && n.w_got && !n.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = addr_ok(n.awaddr) ? `SOM_RESP_OK : `SOM_RESP_ERR;
      case (n.awaddr)
        `SOM_OC_FUNC: begin
          wm = merge({25'h0, q.func[0]}, n.wdata, n.wstrb);
          n.func[0] = wm[6:0];
        end
        `SOM_RY_FUNC: begin
          wm = merge({25'h0, q.func[1]}, n.wdata, n.wstrb);
          n.func[1] = wm[6:0];
        end
        `SOM_POLARITY: begin
          wm = merge({30'h0, q.pol}, n.wdata, n.wstrb);
          n.pol = wm[1:0]; // [R11]
        end
        `SOM_OC_ON: begin
          wm = merge({22'h0, q.on_dly[0]}, n.wdata, n.wstrb);
          n.on_dly[0] = clamp(wm); // [R16] [R17]
        end
        `SOM_OC_OFF: begin
          wm = merge({22'h0, q.off_dly[0]}, n.wdata, n.wstrb);
          n.off_dly[0] = clamp(wm); // [R16] [R17]
        end
        `SOM_RY_ON: begin
          wm = merge({22'h0, q.on_dly[1]}, n.wdata, n.wstrb);
          n.on_dly[1] = clamp(wm); // [R16] [R17]
        end
        `SOM_RY_OFF: begin
          wm = merge({22'h0, q.off_dly[1]}, n.wdata, n.wstrb);
          n.off_dly[1] = clamp(wm); // [R16] [R17]
        end
        `SOM_IRQ_STAT: begin
          if (n.wstrb[0]) begin
            n.ist = q.ist & ~n.wdata[1:0];
          end
        end
        `SOM_IRQ_MASK: begin
          wm = merge({30'h0, q.imask}, n.wdata, n.wstrb);
          n.imask = wm[1:0];
        end
        default: begin
          wm = 32'h0;
        end
      endcase
    end
    // Read channel
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = addr_ok(s_axi_araddr) ? `SOM_RESP_OK : `SOM_RESP_ERR;
      case (s_axi_araddr)
        `SOM_OC_FUNC:  n.rdata = {25'h0, q.func[0]};
        `SOM_RY_FUNC:  n.rdata = {25'h0, q.func[1]};
        `SOM_POLARITY: n.rdata = {30'h0, q.pol};
        `SOM_OC_ON:    n.rdata = {22'h0, q.on_dly[0]};
        `SOM_OC_OFF:   n.rdata = {22'h0, q.off_dly[0]};
        `SOM_RY_ON:    n.rdata = {22'h0, q.on_dly[1]};
        `SOM_RY_OFF:   n.rdata = {22'h0, q.off_dly[1]};
        `SOM_STATUS:   n.rdata = {28'h0, cond, q.act};
        `SOM_IRQ_STAT: n.rdata = {30'h0, q.ist};
        `SOM_IRQ_MASK: n.rdata = {30'h0, q.imask};
        default:       n.rdata = 32'h0;
      endcase
    end
    n.awready = !n.aw_got;
    n.wready = !n.w_got;
    n.arready = !n.rvalid;
    // Delay stage, one per terminal
    for (int c = 0; c < 2; c++) begin
      dly = q.act[c] ? q.off_dly[c] : q.on_dly[c]; // [R16]
      if (cond[c] == q.act[c]) begin
        n.cnt[c] = 10'h0; // [R18]
      end else if (dly == 10'h0) begin
        n.act[c] = cond[c]; // [R15]
        n.cnt[c] = 10'h0;
      end else if (q.cnt[c] > dly) begin
        // One step more than the setting, so a delay never ends short
        n.act[c] = cond[c]; // [R16] [R18]
        n.cnt[c] = 10'h0;
      end else if (q.tick) begin
        n.cnt[c] = q.cnt[c] + 10'h1; // [R19]
      end
      if (n.act[c] != q.act[c]) begin
        n.ist[c] = 1'b1;
      end
    end
    // Polarity after the delay stage
    n.oc = n.act[0] ^ n.pol[0];   // [R12] [R13] [R19]
    n.mk = n.act[1] ^ n.pol[1];   // [R14]
    n.brk = !(n.act[1] ^ n.pol[1]); // [R14]
    n.irq = |(n.ist & n.imask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.func <= {`SOM_RY_FN_RST, `SOM_OC_FN_RST};
      q.pol <= `SOM_POL_RST; // [R14]
      q.brk <= 1'b1;         // [R14]
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready      = q.awready;
  assign s_axi_wready       = q.wready;
  assign s_axi_bvalid       = q.bvalid;
  assign s_axi_bresp        = q.bresp;
  assign s_axi_arready      = q.arready;
  assign s_axi_rvalid       = q.rvalid;
  assign s_axi_rresp        = q.rresp;
  assign s_axi_rdata        = q.rdata;
  assign oc_output_on       = q.oc;
  assign relay_make_closed  = q.mk;
  assign relay_break_closed = q.brk;
  assign irq                = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_oc_rise;
    !q.act[0] && cond[0] && q.cnt[0] == 10'h0 && q.on_dly[0] != 10'h0;
  endsequence

  sequence s_oc_fall;
    q.act[0] && !cond[0] && q.cnt[0] == 10'h0 && q.off_dly[0] != 10'h0;
  endsequence

  chk_unassigned_idle: assert property ( // [R10]
    q.func[0][6] |-> !cond[0])
    else $error("unassigned code drives a condition");

  chk_run_select: assert property ( // [R2]
    q.func[1] == {1'b0, `SOM_C_RUN} |-> cond[1] == run_state)
    else $error("code 00 does not follow running state");

  chk_open_polarity: assert property ( // [R12]
    !q.pol[0] |-> oc_output_on == q.act[0])
    else $error("normally open output wrong");

  chk_closed_polarity: assert property ( // [R13]
    q.pol[0] |-> oc_output_on == !q.act[0])
    else $error("normally closed output wrong");

  chk_relay_contacts: assert property ( // [R14]
    relay_make_closed != relay_break_closed)
    else $error("relay contacts not complementary");

  chk_zero_delay: assert property ( // [R15]
    (q.on_dly[1] == 10'h0 && cond[1] && !q.act[1]) |=> q.act[1])
    else $error("zero on-delay did not pass at once");

  chk_on_hold: assert property ( // [R18]
    s_oc_rise |=> !q.act[0])
    else $error("on-delay expired too early");

  chk_off_hold: assert property ( // [R16]
    s_oc_fall |=> q.act[0])
    else $error("off-delay expired too early");

  chk_delay_range: assert property ( // [R17]
    q.on_dly[0] <= `SOM_DLY_MAX && q.off_dly[1] <= `SOM_DLY_MAX)
    else $error("delay setting out of range");

  chk_step_count: assert property ( // [R19]
    (q.cnt[1] != 10'h0 && !q.tick && cond[1] != q.act[1] && q.cnt[1] <= q.on_dly[1]
     && q.cnt[1] <= q.off_dly[1]) |=> $stable(q.cnt[1]))
    else $error("delay counter moved without a step");

endmodule : som_mapper
`default_nettype wire

//--- testbench/som_reader.sv
// Model of the control equipment that reads the two output terminals
`timescale 1ns/1ps
`default_nettype none
module som_reader (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        oc_output_on,
  input  wire logic        relay_make_closed,
  input  wire logic        relay_break_closed,
  output var  logic        contact_fault,
  output var  logic [15:0] oc_edges
);
  logic oc_q;
  // Counts switchings of the open collector, flags a changeover that is not exclusive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oc_q          <= 1'h0;
      oc_edges      <= 16'h0;
      contact_fault <= 1'h0;
    end else begin
      oc_q <= oc_output_on;
      if (oc_q != oc_output_on) oc_edges <= oc_edges + 16'h1;
      if (relay_make_closed == relay_break_closed) contact_fault <= 1'h1;
    end
  end
endmodule : som_reader
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench of the status output mapper
`timescale 1ns/1ps
`include "som_cfg.svh"
`default_nettype none
module tb_top;
  localparam int TK = 4;
  logic        clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, oc, mk, brk, irq, bad;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [26:0] cond;
  logic [15:0] edges;
  int          fail_count, check_count, cyc;
  logic [6:0]  code [27] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h09, 7'h0B, 7'h0C, 7'h0D, 7'h15,
    7'h1B, 7'h1F, 7'h20, 7'h21, 7'h29, 7'h2A, 7'h2B, 7'h32, 7'h33, 7'h34, 7'h35, 7'h36, 7'h3A, 7'h3B, 7'h3C};
  logic [6:0]  nocode [3] = '{7'h7F, 7'h07, 7'h40};
  som_mapper #(.TICK_CYCLES(TK)) dut (.clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .run_state(cond[0]), .constant_speed_reached(cond[1]),
    .frequency_overreached(cond[2]), .overload_notice(cond[3]), .process_deviation(cond[4]),
    .fault_trip_flag(cond[5]), .set_frequency_reached(cond[6]), .undervoltage_flag(cond[7]),
    .run_time_over(cond[8]), .powered_time_over(cond[9]), .thermal_warning(cond[10]),
    .zero_frequency_detect(cond[11]), .analog_input_loss(cond[12]), .feedback_compare(cond[13]),
    .comm_link_loss(cond[14]), .logic_result_one(cond[15]), .start_contact(cond[16]),
    .heatsink_warning(cond[17]), .low_current_flag(cond[18]), .drive_ready(cond[19]),
    .forward_rotation(cond[20]), .reverse_rotation(cond[21]), .major_fault(cond[22]),
    .window_comparator_flag(cond[23]), .freq_cmd_source_flag(cond[24]), .run_cmd_source_flag(cond[25]),
    .second_motor_active(cond[26]), .oc_output_on(oc), .relay_make_closed(mk), .relay_break_closed(brk),
    .irq(irq));
  som_reader rdr (.clk(clk), .reset_n(reset_n), .oc_output_on(oc), .relay_make_closed(mk),
    .relay_break_closed(brk), .contact_fault(bad), .oc_edges(edges));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] er = 2'h0);
    logic done, ah, wh;
    int   n;
    done = 1'h0;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done && n < 50) begin
      @(negedge clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      done = bvalid;
      n++;
      if (done) chk({30'h0, bresp}, {30'h0, er});
      @(posedge clk);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
      if (done) bready <= 1'h0;
    end
    if (!done) chk(32'h0, 32'h1);
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    logic done, ah;
    int   n;
    done = 1'h0;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done && n < 50) begin
      @(negedge clk);
      ah = arvalid & arready;
      done = rvalid;
      n++;
      if (done) chk({rresp, rdata[29:0]}, {er, exp[29:0]});
      @(posedge clk);
      if (ah) arvalid <= 1'h0;
      if (done) rready <= 1'h0;
    end
    if (!done) chk(32'h0, 32'h1);
  endtask : rdc
  task automatic setc(input logic [26:0] v);
    @(posedge clk);
    cond <= v;
  endtask : setc
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask : wt
  task automatic meas(input logic want, output int n_oc, output int n_ry);
    n_oc = 0;
    n_ry = 0;
    for (int n = 1; n < 80 && (n_oc == 0 || n_ry == 0); n++) begin
      @(negedge clk);
      if (n_oc == 0 && oc === want) n_oc = n;
      if (n_ry == 0 && mk === want) n_ry = n;
    end
  endtask : meas
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    @(negedge clk);
    chk({oc, mk, brk}, 3'h2);
    rdc(`SOM_OC_FUNC, 32'h7F);
    rdc(`SOM_RY_FUNC, 32'h05);
    rdc(`SOM_POLARITY, 32'h2);
    for (int a = 12; a < 40; a += 4) rdc(6'(a), 32'h0);
    rdc(6'h28, 32'h0, `SOM_RESP_ERR);
    wr(6'h2C, 32'hFF, 4'hF, `SOM_RESP_ERR);
    wr(`SOM_POLARITY, 32'h3, 4'h0);
    rdc(`SOM_POLARITY, 32'h2);
    $display("Test reset done");
  endtask : t_reset
  task automatic t_map;
    wr(`SOM_POLARITY, 32'h0);
    for (int i = 0; i < 27; i++) begin
      wr(`SOM_OC_FUNC, {25'h0, code[i]});
      wr(`SOM_RY_FUNC, {25'h0, code[i]});
      setc(~(27'h1 << i));
      wt(2);
      chk({oc, mk, brk}, 3'h1);
      setc(27'h1 << i);
      wt(2);
      chk({oc, mk, brk}, 3'h6);
      rdc(`SOM_STATUS, 32'hF);
    end
    for (int k = 0; k < 3; k++) begin
      wr(`SOM_OC_FUNC, {25'h0, nocode[k]});
      wr(`SOM_RY_FUNC, {25'h0, nocode[k]});
      setc('1);
      wt(2);
      chk({oc, mk}, 2'h0);
    end
    $display("Test mapping done");
  endtask : t_map
  task automatic t_pol;
    wr(`SOM_OC_FUNC, 32'h05);
    wr(`SOM_RY_FUNC, 32'h05);
    wr(`SOM_POLARITY, 32'h3);
    setc(27'h20);
    wt(2);
    chk({oc, mk, brk}, 3'h1);
    setc(27'h0);
    wt(2);
    chk({oc, mk, brk}, 3'h6);
    wr(`SOM_POLARITY, 32'h1);
    setc(27'h20);
    wt(2);
    chk({oc, mk, brk}, 3'h2);
    $display("Test polarity done");
  endtask : t_pol
  task automatic t_delay;
    int no, nr;
    setc(27'h0);
    wr(`SOM_POLARITY, 32'h0);
    wr(`SOM_OC_ON, 32'd2000);
    rdc(`SOM_OC_ON, 32'h3E8);
    wr(`SOM_OC_ON, 32'h3);
    wr(`SOM_OC_OFF, 32'h2);
    wr(`SOM_RY_ON, 32'h1);
    wt(2);
    no = edges;
    setc(27'h20);
    repeat (5) @(posedge clk);
    setc(27'h0);
    wt(30);
    chk({16'h0, edges}, no);
    setc(27'h20);
    meas(1'h1, no, nr);
    chk(no >= 3 * TK && no <= 4 * TK + 3, 1);
    chk(nr >= TK && nr <= 2 * TK + 3, 1);
    setc(27'h0);
    meas(1'h0, no, nr);
    chk(no >= 2 * TK && no <= 3 * TK + 3, 1);
    chk(nr <= 3, 1);
    $display("Test delays done");
  endtask : t_delay
  task automatic t_irq;
    wr(`SOM_OC_ON, 32'h0);
    wr(`SOM_OC_OFF, 32'h0);
    wr(`SOM_RY_ON, 32'h0);
    wr(`SOM_IRQ_STAT, 32'h3);
    rdc(`SOM_IRQ_STAT, 32'h0);
    setc(27'h20);
    wt(3);
    rdc(`SOM_IRQ_STAT, 32'h3);
    chk(irq, 0);
    wr(`SOM_IRQ_MASK, 32'h1);
    wt(1);
    chk(irq, 1);
    wr(`SOM_IRQ_STAT, 32'h1);
    wt(1);
    chk(irq, 0);
    rdc(`SOM_IRQ_STAT, 32'h2);
    wr(`SOM_IRQ_MASK, 32'h2);
    wt(1);
    chk(irq, 1);
    wr(`SOM_IRQ_STAT, 32'h2);
    wt(1);
    chk(irq, 0);
    $display("Test interrupt done");
  endtask : t_irq
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      stop_test;
    end
  end
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb, cond} = '0;
    {fail_count, check_count, cyc} = '0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk({mk, brk}, 2'h1);
    @(posedge clk);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk);
    t_reset;
    t_map;
    t_pol;
    t_delay;
    t_irq;
    chk(bad, 0);
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
